// file: sd_adjust_pkg.sv
// sd_adjust_pkg: offsets, field layout and reset values of the SD adjust bank
// assumes an 8-bit subaddressed register port and one core clock
package sd_adjust_pkg;

    localparam int unsigned NUM_REGS = 13;

    // subaddresses
    localparam logic [7:0] OFF_COPY_GEN_CTRL_HI = 8'h99;
    localparam logic [7:0] OFF_COPY_GEN_PAYLOAD_MID = 8'h9A;
    localparam logic [7:0] OFF_COPY_GEN_PAYLOAD_LO = 8'h9B;
    localparam logic [7:0] OFF_SCALE_PHASE_LOW_BITS = 8'h9C;
    localparam logic [7:0] OFF_LUMA_SCALE_HI = 8'h9D;
    localparam logic [7:0] OFF_BLUE_DIFF_SCALE_HI = 8'h9E;
    localparam logic [7:0] OFF_RED_DIFF_SCALE_HI = 8'h9F;
    localparam logic [7:0] OFF_HUE_ADJUST = 8'hA0;
    localparam logic [7:0] OFF_BRIGHTNESS_WSS_BLANK = 8'hA1;
    localparam logic [7:0] OFF_LUMA_SHAPING_GAIN = 8'hA2;
    localparam logic [7:0] OFF_NOISE_CORING_GAINS = 8'hA3;
    localparam logic [7:0] OFF_NOISE_THRESHOLD = 8'hA4;
    localparam logic [7:0] OFF_NOISE_BLOCK_CTRL = 8'hA5;

    // reset values
    localparam logic [7:0] RST_BANK = 8'h00;
    localparam logic [7:0] RST_NOISE_BLOCK_CTRL = 8'h00;

    // copy_gen_ctrl_hi fields
    localparam int unsigned POS_CGMS_C19_16 = 0;
    localparam int unsigned POS_CGMS_CRC_EN = 4;
    localparam int unsigned POS_CGMS_ODD_EN = 5;
    localparam int unsigned POS_CGMS_EVEN_EN = 6;
    localparam int unsigned POS_WSS_EN = 7;
    // copy_gen_payload_mid fields
    localparam int unsigned POS_PAYLOAD_13_8 = 0;
    localparam int unsigned POS_CGMS_C15_14 = 6;
    // scale_phase_low_bits fields
    localparam int unsigned POS_LUMA_LSB = 0;
    localparam int unsigned POS_BLUE_LSB = 2;
    localparam int unsigned POS_RED_LSB = 4;
    localparam int unsigned POS_PHASE_LSB = 6;
    // brightness_wss_blank fields
    localparam int unsigned POS_BRIGHTNESS = 0;
    localparam int unsigned POS_WSS_BLANK = 7;
    // luma_shaping_gain / noise_coring_gains fields
    localparam int unsigned POS_SHAPING_GAIN = 0;
    localparam int unsigned POS_CORING_BORDER = 0;
    localparam int unsigned POS_CORING_DATA = 4;
    // noise_threshold fields
    localparam int unsigned POS_THRESHOLD = 0;
    localparam int unsigned POS_BORDER_AREA = 6;
    localparam int unsigned POS_BLOCK_SIZE = 7;
    // noise_block_ctrl fields
    localparam int unsigned POS_INPUT_SEL = 0;
    localparam int unsigned POS_NOISE_MODE = 3;
    localparam int unsigned POS_BLOCK_OFFSET = 4;

    // luma shaping filter code for 0 dB, used while the filter is bypassed
    localparam logic [3:0] SHAPING_CODE_0DB = 4'h6;
    localparam logic [3:0] CORING_CODE_MAX = 4'h8;

    // block geometry in pixels
    localparam logic [2:0] BORDER_PX_NARROW = 3'h2;
    localparam logic [2:0] BORDER_PX_WIDE = 3'h4;
    localparam logic [4:0] BLOCK_PX_SMALL = 5'h08;
    localparam logic [4:0] BLOCK_PX_LARGE = 5'h10;

    // noise reduction input filter codes
    localparam logic [2:0] SEL_FILTER_A = 3'h1;
    localparam logic [2:0] SEL_FILTER_B = 3'h2;
    localparam logic [2:0] SEL_FILTER_C = 3'h3;
    localparam logic [2:0] SEL_FILTER_D = 3'h4;

endpackage

// file: coring_gain_decode.sv
// coring_gain_decode: turns a 4-bit coring gain code into sixteenths
// assumes the mode bit comes straight from the bank, same clock
`timescale 1ns/100ps
module coring_gain_decode
    import sd_adjust_pkg::*;
(
    input wire logic [3:0] code,
    input wire logic sharpness_mode,
    output logic signed [5:0] gain_sixteenths
);

    logic [3:0] steps;

    always_comb begin
        // codes above eight saturate rather than wrap
        steps = (code > CORING_CODE_MAX) ? CORING_CODE_MAX : code;
        if (sharpness_mode) begin
            gain_sixteenths = $signed({2'b00, steps});
        end else begin
            gain_sixteenths = -$signed({1'b0, steps, 1'b0});
        end
    end

endmodule

// file: sd_video_adjust_regs.sv
// sd_video_adjust_regs: SD video adjust register bank at 0x99 to 0xA5
// assumes a subaddressed byte port on CLK; outputs feed the SD pipeline
`timescale 1ns/100ps

module sd_video_adjust_regs
    import sd_adjust_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET,
    // register port
    input wire logic [7:0] REGISTER_SUBADDRESS,
    input wire logic WR_EN,
    input wire logic [7:0] WDATA,
    input wire logic RD_EN,
    output logic [7:0] RDATA,
    output logic RD_VALID,
    output logic RD_HIT,
    output logic CONFIG_WRITE,
    // neighbouring registers outside this bank
    input wire logic SHAPING_FILTER_ON,
    input wire logic [7:0] PHASE_HI,
    // copy generation and wide screen signalling
    output logic [19:0] CGMS_PAYLOAD,
    output logic [13:0] WSS_PAYLOAD,
    output logic CGMS_ODD_EN,
    output logic CGMS_EVEN_EN,
    output logic CGMS_CRC_EN,
    output logic WSS_EN,
    output logic WSS_BLANK,
    output logic WSS_ACTIVE,
    // scale, phase, hue, brightness
    output logic [9:0] LUMA_SCALE,
    output logic [9:0] BLUE_DIFF_SCALE,
    output logic [9:0] RED_DIFF_SCALE,
    output logic [9:0] SUBCARRIER_PHASE,
    output logic [7:0] HUE_ADJUST,
    output logic [6:0] BRIGHTNESS,
    // luma shaping filter
    output logic [3:0] SHAPING_GAIN_CODE,
    // noise reduction
    output logic signed [5:0] CORING_BORDER_GAIN,
    output logic signed [5:0] CORING_DATA_GAIN,
    output logic [5:0] NOISE_THRESHOLD,
    output logic [2:0] BORDER_WIDTH_PX,
    output logic [4:0] BLOCK_SIZE_PX,
    output logic [3:0] NOISE_INPUT_SEL,
    output logic NOISE_SEL_VALID,
    output logic NOISE_SHARPNESS_MODE,
    output logic [3:0] BLOCK_OFFSET
);

    typedef struct packed {
        logic [NUM_REGS-1:0][7:0] regs;
        logic [7:0] rdata;
        logic rd_valid;
        logic rd_hit;
        logic wr_pulse;
        logic [9:0] phase;
        logic [3:0] shaping_code;
        logic signed [5:0] border_gain;
        logic signed [5:0] data_gain;
        logic [3:0] input_sel;
        logic sel_valid;
        logic [2:0] border_px;
        logic [4:0] block_px;
    } state_s;

    state_s s_q;
    state_s s_d;

    logic addr_hit;
    logic signed [5:0] border_gain_c;
    logic signed [5:0] data_gain_c;
    logic [7:0] ctrl_hi;
    logic [7:0] payload_mid;
    logic [7:0] payload_lo;
    logic [7:0] low_bits;
    logic [7:0] bright_reg;
    logic [7:0] coring_reg;
    logic [7:0] thresh_reg;
    logic [7:0] block_reg;

    assign addr_hit = (REGISTER_SUBADDRESS >= OFF_COPY_GEN_CTRL_HI) &&
                      (REGISTER_SUBADDRESS <= OFF_NOISE_BLOCK_CTRL);

    // views of the stored bytes by subaddress
    assign ctrl_hi = s_q.regs[OFF_COPY_GEN_CTRL_HI - OFF_COPY_GEN_CTRL_HI];
    assign payload_mid = s_q.regs[OFF_COPY_GEN_PAYLOAD_MID - OFF_COPY_GEN_CTRL_HI];
    assign payload_lo = s_q.regs[OFF_COPY_GEN_PAYLOAD_LO - OFF_COPY_GEN_CTRL_HI];
    assign low_bits = s_q.regs[OFF_SCALE_PHASE_LOW_BITS - OFF_COPY_GEN_CTRL_HI];
    assign bright_reg = s_q.regs[OFF_BRIGHTNESS_WSS_BLANK - OFF_COPY_GEN_CTRL_HI];
    assign coring_reg = s_q.regs[OFF_NOISE_CORING_GAINS - OFF_COPY_GEN_CTRL_HI];
    assign thresh_reg = s_q.regs[OFF_NOISE_THRESHOLD - OFF_COPY_GEN_CTRL_HI];
    assign block_reg = s_q.regs[OFF_NOISE_BLOCK_CTRL - OFF_COPY_GEN_CTRL_HI];

    // one decoder per coring field; both follow the shared mode bit
    coring_gain_decode u_border_gain (
        .code(coring_reg[POS_CORING_BORDER +: 4]),
        .sharpness_mode(block_reg[POS_NOISE_MODE]),
        .gain_sixteenths(border_gain_c)
    );

    coring_gain_decode u_data_gain (
        .code(coring_reg[POS_CORING_DATA +: 4]),
        .sharpness_mode(block_reg[POS_NOISE_MODE]),
        .gain_sixteenths(data_gain_c)
    );

    always_comb begin
        s_d = s_q;
        s_d.wr_pulse = 1'b0;
        s_d.rd_valid = 1'b0;

        // writes land one edge after WR_EN; a read in the same cycle sees the old byte
        // flat decode per subaddress keeps the adder out of the write path
        if (WR_EN) begin
            s_d.wr_pulse = 1'b1;
            case (REGISTER_SUBADDRESS)
                OFF_COPY_GEN_CTRL_HI: begin
                    s_d.regs[OFF_COPY_GEN_CTRL_HI - OFF_COPY_GEN_CTRL_HI] = WDATA;
                end
                OFF_COPY_GEN_PAYLOAD_MID: begin
                    s_d.regs[OFF_COPY_GEN_PAYLOAD_MID - OFF_COPY_GEN_CTRL_HI] = WDATA;
                end
                OFF_COPY_GEN_PAYLOAD_LO: begin
                    s_d.regs[OFF_COPY_GEN_PAYLOAD_LO - OFF_COPY_GEN_CTRL_HI] = WDATA;
                end
                OFF_SCALE_PHASE_LOW_BITS: begin
                    s_d.regs[OFF_SCALE_PHASE_LOW_BITS - OFF_COPY_GEN_CTRL_HI] = WDATA;
                end
                OFF_LUMA_SCALE_HI: begin
                    s_d.regs[OFF_LUMA_SCALE_HI - OFF_COPY_GEN_CTRL_HI] = WDATA;
                end
                OFF_BLUE_DIFF_SCALE_HI: begin
                    s_d.regs[OFF_BLUE_DIFF_SCALE_HI - OFF_COPY_GEN_CTRL_HI] = WDATA;
                end
                OFF_RED_DIFF_SCALE_HI: begin
                    s_d.regs[OFF_RED_DIFF_SCALE_HI - OFF_COPY_GEN_CTRL_HI] = WDATA;
                end
                OFF_HUE_ADJUST: begin
                    s_d.regs[OFF_HUE_ADJUST - OFF_COPY_GEN_CTRL_HI] = WDATA;
                end
                OFF_BRIGHTNESS_WSS_BLANK: begin
                    s_d.regs[OFF_BRIGHTNESS_WSS_BLANK - OFF_COPY_GEN_CTRL_HI] = WDATA;
                end
                OFF_LUMA_SHAPING_GAIN: begin
                    s_d.regs[OFF_LUMA_SHAPING_GAIN - OFF_COPY_GEN_CTRL_HI] = WDATA;
                end
                OFF_NOISE_CORING_GAINS: begin
                    s_d.regs[OFF_NOISE_CORING_GAINS - OFF_COPY_GEN_CTRL_HI] = WDATA;
                end
                OFF_NOISE_THRESHOLD: begin
                    s_d.regs[OFF_NOISE_THRESHOLD - OFF_COPY_GEN_CTRL_HI] = WDATA;
                end
                OFF_NOISE_BLOCK_CTRL: begin
                    s_d.regs[OFF_NOISE_BLOCK_CTRL - OFF_COPY_GEN_CTRL_HI] = WDATA;
                end
                default: begin
                    s_d.wr_pulse = 1'b0;
                end
            endcase
        end

        // unmapped subaddresses read as zero and drop RD_HIT
        // read byte is registered, so it stands until the next read strobe
        if (RD_EN) begin
            s_d.rd_valid = 1'b1;
            s_d.rd_hit = addr_hit;
            case (REGISTER_SUBADDRESS)
                OFF_COPY_GEN_CTRL_HI: begin
                    s_d.rdata = s_q.regs[OFF_COPY_GEN_CTRL_HI - OFF_COPY_GEN_CTRL_HI];
                end
                OFF_COPY_GEN_PAYLOAD_MID: begin
                    s_d.rdata = s_q.regs[OFF_COPY_GEN_PAYLOAD_MID - OFF_COPY_GEN_CTRL_HI];
                end
                OFF_COPY_GEN_PAYLOAD_LO: begin
                    s_d.rdata = s_q.regs[OFF_COPY_GEN_PAYLOAD_LO - OFF_COPY_GEN_CTRL_HI];
                end
                OFF_SCALE_PHASE_LOW_BITS: begin
                    s_d.rdata = s_q.regs[OFF_SCALE_PHASE_LOW_BITS - OFF_COPY_GEN_CTRL_HI];
                end
                OFF_LUMA_SCALE_HI: begin
                    s_d.rdata = s_q.regs[OFF_LUMA_SCALE_HI - OFF_COPY_GEN_CTRL_HI];
                end
                OFF_BLUE_DIFF_SCALE_HI: begin
                    s_d.rdata = s_q.regs[OFF_BLUE_DIFF_SCALE_HI - OFF_COPY_GEN_CTRL_HI];
                end
                OFF_RED_DIFF_SCALE_HI: begin
                    s_d.rdata = s_q.regs[OFF_RED_DIFF_SCALE_HI - OFF_COPY_GEN_CTRL_HI];
                end
                OFF_HUE_ADJUST: begin
                    s_d.rdata = s_q.regs[OFF_HUE_ADJUST - OFF_COPY_GEN_CTRL_HI];
                end
                OFF_BRIGHTNESS_WSS_BLANK: begin
                    s_d.rdata = s_q.regs[OFF_BRIGHTNESS_WSS_BLANK - OFF_COPY_GEN_CTRL_HI];
                end
                OFF_LUMA_SHAPING_GAIN: begin
                    s_d.rdata = s_q.regs[OFF_LUMA_SHAPING_GAIN - OFF_COPY_GEN_CTRL_HI];
                end
                OFF_NOISE_CORING_GAINS: begin
                    s_d.rdata = s_q.regs[OFF_NOISE_CORING_GAINS - OFF_COPY_GEN_CTRL_HI];
                end
                OFF_NOISE_THRESHOLD: begin
                    s_d.rdata = s_q.regs[OFF_NOISE_THRESHOLD - OFF_COPY_GEN_CTRL_HI];
                end
                OFF_NOISE_BLOCK_CTRL: begin
                    s_d.rdata = s_q.regs[OFF_NOISE_BLOCK_CTRL - OFF_COPY_GEN_CTRL_HI];
                end
                default: begin
                    s_d.rdata = 8'h00;
                end
            endcase
        end

        // phase high bits live outside the bank; both halves retimed together
        s_d.phase = {PHASE_HI, low_bits[POS_PHASE_LSB +: 2]};

        // bypassed filter is forced to its unity code
        if (SHAPING_FILTER_ON) begin
            s_d.shaping_code =
                s_q.regs[OFF_LUMA_SHAPING_GAIN - OFF_COPY_GEN_CTRL_HI][POS_SHAPING_GAIN +: 4];
        end else begin
            s_d.shaping_code = SHAPING_CODE_0DB;
        end

        s_d.border_gain = border_gain_c;
        s_d.data_gain = data_gain_c;

        s_d.border_px = thresh_reg[POS_BORDER_AREA] ? BORDER_PX_WIDE : BORDER_PX_NARROW;
        s_d.block_px = thresh_reg[POS_BLOCK_SIZE] ? BLOCK_PX_LARGE : BLOCK_PX_SMALL;

        // codes outside A..D select nothing rather than a guessed filter
        s_d.sel_valid = 1'b1;
        case (block_reg[POS_INPUT_SEL +: 3])
            SEL_FILTER_A: s_d.input_sel = 4'b0001;
            SEL_FILTER_B: s_d.input_sel = 4'b0010;
            SEL_FILTER_C: s_d.input_sel = 4'b0100;
            SEL_FILTER_D: s_d.input_sel = 4'b1000;
            default: begin
                s_d.input_sel = 4'b0000;
                s_d.sel_valid = 1'b0;
            end
        endcase

        // reset wins over any strobe in the same cycle
        if (RESET) begin
            s_d.regs[OFF_COPY_GEN_CTRL_HI - OFF_COPY_GEN_CTRL_HI] = RST_BANK;
            s_d.regs[OFF_COPY_GEN_PAYLOAD_MID - OFF_COPY_GEN_CTRL_HI] = RST_BANK;
            s_d.regs[OFF_COPY_GEN_PAYLOAD_LO - OFF_COPY_GEN_CTRL_HI] = RST_BANK;
            s_d.regs[OFF_SCALE_PHASE_LOW_BITS - OFF_COPY_GEN_CTRL_HI] = RST_BANK;
            s_d.regs[OFF_LUMA_SCALE_HI - OFF_COPY_GEN_CTRL_HI] = RST_BANK;
            s_d.regs[OFF_BLUE_DIFF_SCALE_HI - OFF_COPY_GEN_CTRL_HI] = RST_BANK;
            s_d.regs[OFF_RED_DIFF_SCALE_HI - OFF_COPY_GEN_CTRL_HI] = RST_BANK;
            s_d.regs[OFF_HUE_ADJUST - OFF_COPY_GEN_CTRL_HI] = RST_BANK;
            s_d.regs[OFF_BRIGHTNESS_WSS_BLANK - OFF_COPY_GEN_CTRL_HI] = RST_BANK;
            s_d.regs[OFF_LUMA_SHAPING_GAIN - OFF_COPY_GEN_CTRL_HI] = RST_BANK;
            s_d.regs[OFF_NOISE_CORING_GAINS - OFF_COPY_GEN_CTRL_HI] = RST_BANK;
            s_d.regs[OFF_NOISE_THRESHOLD - OFF_COPY_GEN_CTRL_HI] = RST_BANK;
            s_d.regs[OFF_NOISE_BLOCK_CTRL - OFF_COPY_GEN_CTRL_HI] = RST_NOISE_BLOCK_CTRL;
            s_d.rdata = 8'h00;
            s_d.rd_valid = 1'b0;
            s_d.rd_hit = 1'b0;
            s_d.wr_pulse = 1'b0;
            s_d.phase = 10'h000;
            s_d.shaping_code = SHAPING_CODE_0DB;
            s_d.border_gain = 6'sh00;
            s_d.data_gain = 6'sh00;
            s_d.input_sel = 4'b0000;
            s_d.sel_valid = 1'b0;
            s_d.border_px = BORDER_PX_NARROW;
            s_d.block_px = BLOCK_PX_SMALL;
        end
    end

    // one register stage for the whole bank; reset is synchronous
    always_ff @(posedge CLK) begin
        s_q <= s_d;
    end

    assign RDATA = s_q.rdata;
    assign RD_VALID = s_q.rd_valid;
    assign RD_HIT = s_q.rd_hit;
    assign CONFIG_WRITE = s_q.wr_pulse;

    // payload bit 19 down to 0; the low 14 bits are shared with wide screen data
    assign CGMS_PAYLOAD = {ctrl_hi[POS_CGMS_C19_16 +: 4],
                           payload_mid[POS_CGMS_C15_14 +: 2],
                           payload_mid[POS_PAYLOAD_13_8 +: 6],
                           payload_lo};
    assign WSS_PAYLOAD = {payload_mid[POS_PAYLOAD_13_8 +: 6], payload_lo};

    assign CGMS_ODD_EN = ctrl_hi[POS_CGMS_ODD_EN];
    assign CGMS_EVEN_EN = ctrl_hi[POS_CGMS_EVEN_EN];
    assign CGMS_CRC_EN = ctrl_hi[POS_CGMS_CRC_EN];
    assign WSS_EN = ctrl_hi[POS_WSS_EN];
    assign WSS_BLANK = bright_reg[POS_WSS_BLANK];
    // blanking wins over enable so software can mute data without losing setup
    assign WSS_ACTIVE = ctrl_hi[POS_WSS_EN] & ~bright_reg[POS_WSS_BLANK];

    assign LUMA_SCALE = {s_q.regs[OFF_LUMA_SCALE_HI - OFF_COPY_GEN_CTRL_HI],
                         low_bits[POS_LUMA_LSB +: 2]};
    assign BLUE_DIFF_SCALE = {s_q.regs[OFF_BLUE_DIFF_SCALE_HI - OFF_COPY_GEN_CTRL_HI],
                              low_bits[POS_BLUE_LSB +: 2]};
    assign RED_DIFF_SCALE = {s_q.regs[OFF_RED_DIFF_SCALE_HI - OFF_COPY_GEN_CTRL_HI],
                             low_bits[POS_RED_LSB +: 2]};
    assign SUBCARRIER_PHASE = s_q.phase;
    assign HUE_ADJUST = s_q.regs[OFF_HUE_ADJUST - OFF_COPY_GEN_CTRL_HI];
    assign BRIGHTNESS = bright_reg[POS_BRIGHTNESS +: 7];

    assign SHAPING_GAIN_CODE = s_q.shaping_code;
    assign CORING_BORDER_GAIN = s_q.border_gain;
    assign CORING_DATA_GAIN = s_q.data_gain;
    assign NOISE_THRESHOLD = thresh_reg[POS_THRESHOLD +: 6];
    assign BORDER_WIDTH_PX = s_q.border_px;
    assign BLOCK_SIZE_PX = s_q.block_px;
    assign NOISE_INPUT_SEL = s_q.input_sel;
    assign NOISE_SEL_VALID = s_q.sel_valid;
    assign NOISE_SHARPNESS_MODE = block_reg[POS_NOISE_MODE];
    assign BLOCK_OFFSET = block_reg[POS_BLOCK_OFFSET +: 4];

endmodule

// file: sd_adjust_chk.sv
// sd_adjust_chk: port-level assertions for the SD adjust bank
// assumes one core clock and a synchronous active-high reset
`timescale 1ns/100ps
module sd_adjust_chk
    import sd_adjust_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET,
    input wire logic [7:0] REGISTER_SUBADDRESS,
    input wire logic WR_EN,
    input wire logic [7:0] WDATA,
    input wire logic RD_EN,
    input wire logic RD_VALID,
    input wire logic RD_HIT,
    input wire logic CONFIG_WRITE,
    input wire logic SHAPING_FILTER_ON,
    input wire logic [7:0] PHASE_HI,
    input wire logic [19:0] CGMS_PAYLOAD,
    input wire logic [13:0] WSS_PAYLOAD,
    input wire logic WSS_EN,
    input wire logic WSS_BLANK,
    input wire logic WSS_ACTIVE,
    input wire logic [9:0] LUMA_SCALE,
    input wire logic [9:0] SUBCARRIER_PHASE,
    input wire logic [7:0] HUE_ADJUST,
    input wire logic [3:0] SHAPING_GAIN_CODE,
    input wire logic [5:0] NOISE_THRESHOLD,
    input wire logic [2:0] BORDER_WIDTH_PX,
    input wire logic [3:0] NOISE_INPUT_SEL,
    input wire logic NOISE_SEL_VALID
);
    logic mapped;
    assign mapped = REGISTER_SUBADDRESS >= 8'h99 && REGISTER_SUBADDRESS <= 8'hA5;
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    AST_WRITE_ACK: assert property (WR_EN |=> CONFIG_WRITE == $past(mapped))
        else $error("write acknowledge wrong");
    AST_READ_HIT: assert property (RD_EN |=> RD_VALID && RD_HIT == $past(mapped))
        else $error("read answer wrong");
    AST_LUMA_HI: assert property (WR_EN && REGISTER_SUBADDRESS == OFF_LUMA_SCALE_HI
        |=> LUMA_SCALE[9:2] == $past(WDATA)) else $error("luma high byte not loaded");
    AST_HUE: assert property (WR_EN && REGISTER_SUBADDRESS == OFF_HUE_ADJUST
        |=> HUE_ADJUST == $past(WDATA)) else $error("hue not loaded");
    AST_PHASE_HI: assert property (!$past(RESET)
        |-> SUBCARRIER_PHASE[9:2] == $past(PHASE_HI)) else $error("phase high bits wrong");
    AST_SHAPING_BYPASS: assert property (!$past(RESET) && !$past(SHAPING_FILTER_ON)
        |-> SHAPING_GAIN_CODE == SHAPING_CODE_0DB) else $error("shaping gain not 0 dB");
    AST_WSS_ACTIVE: assert property (WSS_ACTIVE == (WSS_EN && !WSS_BLANK))
        else $error("wide screen active wrong");
    AST_SHARED_PAYLOAD: assert property (CGMS_PAYLOAD[13:0] == WSS_PAYLOAD)
        else $error("shared payload differs");
    AST_NOISE_GEOM: assert property (WR_EN && REGISTER_SUBADDRESS == OFF_NOISE_THRESHOLD
        |=> NOISE_THRESHOLD == $past(WDATA[5:0]) ##1
        BORDER_WIDTH_PX == ($past(WDATA[6], 2) ? BORDER_PX_WIDE : BORDER_PX_NARROW))
        else $error("threshold or border wrong");
    AST_SEL_ONEHOT: assert property (NOISE_SEL_VALID == (NOISE_INPUT_SEL != 4'h0)
        && $onehot0(NOISE_INPUT_SEL)) else $error("input select not one-hot");
endmodule

bind sd_video_adjust_regs sd_adjust_chk chk_u (.CLK(CLK), .RESET(RESET),
    .REGISTER_SUBADDRESS(REGISTER_SUBADDRESS), .WR_EN(WR_EN), .WDATA(WDATA), .RD_EN(RD_EN),
    .RD_VALID(RD_VALID), .RD_HIT(RD_HIT), .CONFIG_WRITE(CONFIG_WRITE),
    .SHAPING_FILTER_ON(SHAPING_FILTER_ON), .PHASE_HI(PHASE_HI), .CGMS_PAYLOAD(CGMS_PAYLOAD),
    .WSS_PAYLOAD(WSS_PAYLOAD), .WSS_EN(WSS_EN), .WSS_BLANK(WSS_BLANK), .WSS_ACTIVE(WSS_ACTIVE),
    .LUMA_SCALE(LUMA_SCALE), .SUBCARRIER_PHASE(SUBCARRIER_PHASE), .HUE_ADJUST(HUE_ADJUST),
    .SHAPING_GAIN_CODE(SHAPING_GAIN_CODE), .NOISE_THRESHOLD(NOISE_THRESHOLD),
    .BORDER_WIDTH_PX(BORDER_WIDTH_PX), .NOISE_INPUT_SEL(NOISE_INPUT_SEL),
    .NOISE_SEL_VALID(NOISE_SEL_VALID));

// file: tb.sv
// tb: register-port tests of the SD adjust bank
// assumes the bank is the only device; the bench stands in for 0x87 and 0x90
`timescale 1ns/100ps
module tb import sd_adjust_pkg::*;;
    logic CLK, RESET, WR_EN, RD_EN, SHAPING_FILTER_ON, RD_VALID, RD_HIT, CONFIG_WRITE;
    logic [7:0] REGISTER_SUBADDRESS, WDATA, PHASE_HI, RDATA, HUE_ADJUST;
    logic [19:0] CGMS_PAYLOAD;
    logic [13:0] WSS_PAYLOAD;
    logic odd_en, even_en, crc_en, WSS_EN, WSS_BLANK, WSS_ACTIVE, sel_valid, sharp;
    logic [9:0] luma, blue, red, phase;
    logic [6:0] bright;
    logic [3:0] shaping, sel, offset;
    logic signed [5:0] border_gain, data_gain, exp6;
    logic [5:0] thresh;
    logic [2:0] border_px;
    logic [4:0] block_px;
    logic [7:0] pat [13] = '{8'hD3, 8'h9C, 8'h5A, 8'hE4, 8'h12, 8'h34, 8'h56, 8'h78, 8'h2B,
        8'h09, 8'h35, 8'hC7, 8'hB3};
    int failures = 0, samples_checked = 0, cycles = 0, i, m, g;

    sd_video_adjust_regs dut_u (.CLK(CLK), .RESET(RESET),
        .REGISTER_SUBADDRESS(REGISTER_SUBADDRESS), .WR_EN(WR_EN), .WDATA(WDATA), .RD_EN(RD_EN),
        .RDATA(RDATA), .RD_VALID(RD_VALID), .RD_HIT(RD_HIT), .CONFIG_WRITE(CONFIG_WRITE),
        .SHAPING_FILTER_ON(SHAPING_FILTER_ON), .PHASE_HI(PHASE_HI), .CGMS_PAYLOAD(CGMS_PAYLOAD),
        .WSS_PAYLOAD(WSS_PAYLOAD), .CGMS_ODD_EN(odd_en), .CGMS_EVEN_EN(even_en),
        .CGMS_CRC_EN(crc_en), .WSS_EN(WSS_EN), .WSS_BLANK(WSS_BLANK), .WSS_ACTIVE(WSS_ACTIVE),
        .LUMA_SCALE(luma), .BLUE_DIFF_SCALE(blue), .RED_DIFF_SCALE(red),
        .SUBCARRIER_PHASE(phase), .HUE_ADJUST(HUE_ADJUST), .BRIGHTNESS(bright),
        .SHAPING_GAIN_CODE(shaping), .CORING_BORDER_GAIN(border_gain),
        .CORING_DATA_GAIN(data_gain), .NOISE_THRESHOLD(thresh), .BORDER_WIDTH_PX(border_px),
        .BLOCK_SIZE_PX(block_px), .NOISE_INPUT_SEL(sel), .NOISE_SEL_VALID(sel_valid),
        .NOISE_SHARPNESS_MODE(sharp), .BLOCK_OFFSET(offset));

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_of_test();
        if (failures == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // one strobe cycle, then an idle cycle so strobes never merge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge CLK);
        REGISTER_SUBADDRESS = a;
        WDATA = d;
        WR_EN = 1'b1;
        @(negedge CLK);
        WR_EN = 1'b0;
        chk("config write", CONFIG_WRITE, a >= 8'h99 && a <= 8'hA5);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge CLK);
        REGISTER_SUBADDRESS = a;
        RD_EN = 1'b1;
        @(negedge CLK);
        RD_EN = 1'b0;
        chk("read valid", RD_VALID, 1'b1);
        chk("read hit", RD_HIT, a >= 8'h99 && a <= 8'hA5);
        chk("read data", RDATA, e);
    endtask

    initial begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end

    // whole run needs well under 2000 cycles
    always @(posedge CLK) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            end_of_test();
        end
    end

    initial begin
        RESET = 1'b1;
        WR_EN = 1'b0;
        RD_EN = 1'b0;
        REGISTER_SUBADDRESS = 8'h00;
        WDATA = 8'h00;
        SHAPING_FILTER_ON = 1'b0;
        PHASE_HI = 8'hC3;
        repeat (20) @(negedge CLK);
        RESET = 1'b0;
        for (i = 0; i < NUM_REGS; i++) rd(8'(8'h99 + i), 8'h00);
        chk("shaping", shaping, 4'h6);
        chk("border px", border_px, 3'h2);
        chk("block px", block_px, 5'h08);
        chk("sel valid", sel_valid, 1'b0);
        for (i = 0; i < NUM_REGS; i++) wr(8'(8'h99 + i), pat[i]);
        for (i = 0; i < NUM_REGS; i++) rd(8'(8'h99 + i), pat[i]);
        chk("cgms", CGMS_PAYLOAD, 20'h3_9C5A);
        chk("wss", WSS_PAYLOAD, 14'h1C5A);
        chk("enables", {WSS_EN, even_en, odd_en, crc_en}, 4'hD);
        chk("luma", luma, 10'h048);
        chk("blue", blue, 10'h0D1);
        chk("red", red, 10'h15A);
        chk("phase", phase, 10'h30F);
        chk("hue", HUE_ADJUST, 8'h78);
        chk("bright", {WSS_ACTIVE, bright}, 8'hAB);
        chk("shaping off", shaping, 4'h6);
        chk("thresh", {block_px, border_px, thresh}, {5'h10, 3'h4, 6'h07});
        chk("sel", {sel_valid, sel, sharp, offset}, {1'b1, 4'h4, 1'b0, 4'hB});
        SHAPING_FILTER_ON = 1'b1;
        repeat (2) @(negedge CLK);
        chk("shaping on", shaping, 4'h9);
        wr(8'hA1, 8'hAB);
        chk("blank", {WSS_BLANK, WSS_ACTIVE, bright}, {2'h2, 7'h2B});
        // codes above 8 saturate; select codes above 4 are invalid
        for (m = 0; m < 2; m++) begin
            for (i = 0; i < 10; i++) begin
                wr(8'hA5, {i[3:0], m[0], i[2:0]});
                wr(8'hA3, {i[3:0], i[3:0]});
                @(negedge CLK);
                g = i > 8 ? 8 : i;
                exp6 = 6'(m ? g : -2 * g);
                chk("border gain", border_gain, exp6);
                chk("data gain", data_gain, exp6);
                chk("sel code", sel, (i[2:0] >= 1 && i[2:0] <= 4) ? 4'h1 << (i[2:0] - 1) : 4'h0);
                chk("mode offset", {sharp, offset}, {m[0], i[3:0]});
            end
        end
        wr(8'h98, 8'hFF);
        wr(8'hA6, 8'hFF);
        rd(8'h98, 8'h00);
        rd(8'hA6, 8'h00);
        rd(8'h9B, 8'h5A);
        // reset in mid-run must clear the bank again
        RESET = 1'b1;
        repeat (2) @(negedge CLK);
        RESET = 1'b0;
        rd(8'h9D, 8'h00);
        end_of_test();
    end
endmodule
